/* core/imd_top.sv */
// APB slave, run sequencing and flag registers of the multiply/divide unit.
// Assumes an APB master on pclk; registers are 4-bit nibbles in word slots.
module imd_top
	import imd_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq
);

	imd_alu_if alu_bus();

	// Software-visible state
	logic [7:0]     src;
	logic [7:0]     dl;
	logic [7:0]     dh;
	logic           nf;
	logic           vf;
	logic           zf;

	// Run state
	imd_state_t     state;
	imd_mode_t      op_mode;
	logic [CNT_W-1:0] cnt;
	logic [7:0]     op_src;
	logic [7:0]     op_dl;
	logic [7:0]     op_dh;

	logic           busy;
	logic           done;
	logic           wr;
	logic           start_wr;
	logic [IDX_W-1:0] idx;
	logic [3:0]     wnib;
	logic [IRQ_N-1:0] irq_stat;
	logic [IRQ_N-1:0] irq_mask;
	logic [IRQ_N-1:0] evt;

	logic [7:0]     next_src;
	logic [7:0]     next_dl;
	logic [7:0]     next_dh;
	logic           next_nf;
	logic           next_vf;
	logic           next_zf;
	imd_state_t     next_state;
	imd_mode_t      next_op_mode;
	logic [CNT_W-1:0] next_cnt;
	logic [7:0]     next_op_src;
	logic [7:0]     next_op_dl;
	logic [7:0]     next_op_dh;
	logic [31:0]    next_prdata;
	logic           next_pready;
	logic           next_pslverr;

	// Bus decode
	always_comb begin
		idx      = imd_idx(paddr);
		wnib     = pwdata[3:0];
		wr       = psel & penable & pready & pwrite & pstrb[0];
		busy     = (state == IMD_RUN);
		done     = busy && (cnt == CNT_W'(OP_CYCLES - 4'h1)); // RULE9
		// Restart while running is ignored so captured operands stay valid
		start_wr = wr && (idx == IDX_CTRL) && !busy; // RULE6
	end

	// APB answer: ready in the first access cycle, data captured in setup
	always_comb begin
		next_pready  = psel & ~penable;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0000_0000;
		if (psel && !penable) begin
			case (idx)
				IDX_SRC_LO:   next_prdata[3:0] = src[3:0];
				IDX_SRC_HI:   next_prdata[3:0] = src[7:4];
				IDX_DL_LO:    next_prdata[3:0] = dl[3:0];
				IDX_DL_HI:    next_prdata[3:0] = dl[7:4];
				IDX_DH_LO:    next_prdata[3:0] = dh[3:0];
				IDX_DH_HI:    next_prdata[3:0] = dh[7:4];
				IDX_CTRL: begin
					next_prdata[NF_BIT]   = nf; // RULE11
					next_prdata[VF_BIT]   = vf; // RULE1
					next_prdata[ZF_BIT]   = zf; // RULE4
					next_prdata[MODE_BIT] = busy; // RULE7
				end
				IDX_IRQ_STAT: next_prdata[IRQ_N-1:0] = irq_stat;
				IDX_IRQ_MASK: next_prdata[IRQ_N-1:0] = irq_mask;
				default:      next_pslverr = 1'b1;
			endcase
		end
	end

	// Operand registers; results land on the finishing edge
	always_comb begin
		next_src = src;
		next_dl  = dl;
		next_dh  = dh;
		if (wr && idx == IDX_SRC_LO) begin
			next_src[3:0] = wnib;
		end
		if (wr && idx == IDX_SRC_HI) begin
			next_src[7:4] = wnib;
		end
		// Destination is locked while the unit owns it
		if (wr && !busy) begin
			if (idx == IDX_DL_LO) begin
				next_dl[3:0] = wnib;
			end
			if (idx == IDX_DL_HI) begin
				next_dl[7:4] = wnib;
			end
			if (idx == IDX_DH_LO) begin
				next_dh[3:0] = wnib;
			end
			if (idx == IDX_DH_HI) begin
				next_dh[7:4] = wnib;
			end
		end
		if (done) begin
			next_dl = alu_bus.res_lo; // RULE12 RULE13 RULE15
			next_dh = alu_bus.res_hi; // RULE12 RULE13 RULE15
		end
	end

	// Flags change only when a run finishes; bus writes never reach them
	always_comb begin
		next_nf = nf;
		next_vf = vf;
		next_zf = zf;
		if (done) begin
			next_nf = alu_bus.nf; // RULE11 RULE15
			next_vf = alu_bus.vf; // RULE1 RULE2 RULE3 RULE15
			next_zf = alu_bus.zf; // RULE4 RULE5 RULE15
		end
	end

	// Run sequencer
	always_comb begin
		next_state   = state;
		next_op_mode = op_mode;
		next_cnt     = cnt;
		next_op_src  = op_src;
		next_op_dl   = op_dl;
		next_op_dh   = op_dh;
		case (state)
			IMD_IDLE: begin
				if (start_wr) begin
					next_state   = IMD_RUN; // RULE7
					next_op_mode = imd_mode_t'(wnib[MODE_BIT]); // RULE6
					next_cnt     = '0;
					next_op_src  = src;
					next_op_dl   = dl;
					next_op_dh   = dh;
				end
			end
			IMD_RUN: begin
				next_cnt = CNT_W'(cnt + 1'b1);
				if (done) begin
					next_state = IMD_IDLE; // RULE7 RULE9
				end
			end
			default: next_state = IMD_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src     <= BYTE_RST;
			dl      <= BYTE_RST;
			dh      <= BYTE_RST;
			nf      <= 1'b0; // RULE11
			vf      <= 1'b0; // RULE3
			zf      <= 1'b0; // RULE5
			state   <= IMD_IDLE; // RULE8
			op_mode <= IMD_MUL;
			cnt     <= '0;
			op_src  <= BYTE_RST;
			op_dl   <= BYTE_RST;
			op_dh   <= BYTE_RST;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			src     <= next_src;
			dl      <= next_dl;
			dh      <= next_dh;
			nf      <= next_nf;
			vf      <= next_vf;
			zf      <= next_zf;
			state   <= next_state;
			op_mode <= next_op_mode;
			cnt     <= next_cnt;
			op_src  <= next_op_src;
			op_dl   <= next_op_dl;
			op_dh   <= next_op_dh;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign alu_bus.mode = op_mode;
	assign alu_bus.src  = op_src;
	assign alu_bus.dl   = op_dl;
	assign alu_bus.dh   = op_dh;

	imd_alu u_alu (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (alu_bus)
	);

	assign evt[IRQ_DONE_BIT] = done;
	assign evt[IRQ_OVF_BIT]  = done && alu_bus.vf;

	imd_irq #(
		.N (IRQ_N)
	) u_irq (
		.pclk    (pclk),
		.presetn (presetn),
		.evt     (evt),
		.stat_wr (wr && idx == IDX_IRQ_STAT),
		.mask_wr (wr && idx == IDX_IRQ_MASK),
		.wdata   (wnib[IRQ_N-1:0]),
		.stat    (irq_stat),
		.mask    (irq_mask),
		.irq     (irq)
	);

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Busy is seen from the edge after the start through the finishing edge
	sequence run_ten_s;
		busy [*8] ##1 busy [*2] ##1 !busy;
	endsequence

	sequence div_done_s;
		done && (op_mode == IMD_DIV);
	endsequence

	run_length_a: assert property (start_wr |=> run_ten_s) // RULE9
		else $error("run did not last ten cycles");
	start_mode_a: assert property (start_wr |=> op_mode == imd_mode_t'($past(pwdata[0]))) // RULE6
		else $error("mode not taken from written bit");
	busy_read_a: assert property (psel && !penable && idx == IDX_CTRL |=> prdata[0] == $past(busy)) // RULE7
		else $error("status bit does not show run");
	mul_clears_vf_a: assert property (done && op_mode == IMD_MUL |=> !vf) // RULE2
		else $error("overflow left set after multiply");
	vf_stable_a: assert property (!done |=> $stable(vf)) // RULE3
		else $error("overflow changed outside finish");
	zf_stable_a: assert property (!done |=> $stable(zf) && $stable(nf)) // RULE5
		else $error("flag changed outside finish");
	div_ovf_flag_a: assert property (div_done_s |=> vf == ($past(op_dh) >= $past(op_src))) // RULE1
		else $error("overflow flag wrong after divide");
	div_keep_a: assert property (div_done_s and (op_dh >= op_src) |=>
		dl == $past(op_dl) && dh == $past(op_dh)) // RULE13
		else $error("dividend not kept on overflow");
	div_sign_a: assert property (div_done_s and (op_dh < op_src) |=>
		nf == dl[7] && zf == (dl == 8'h00)) // RULE14
		else $error("divide flags disagree with quotient");
	mul_prod_a: assert property (done && op_mode == IMD_MUL |=>
		{dh, dl} == {8'h00, $past(op_src)} * {8'h00, $past(op_dl)}) // RULE12
		else $error("product not loaded");
	flags_sync_a: assert property ($fell(busy) |-> $past(done) && $changed(irq_stat) ||
		irq_stat[IRQ_DONE_BIT]) // RULE15
		else $error("finish not seen together with idle");
	irq_level_a: assert property (##1 irq == |($past(irq_stat) & $past(irq_mask)) ||
		(|$past(evt)) || $past(wr))
		else $error("interrupt level wrong");

	sequence apb_setup_s;
		psel && !penable;
	endsequence

	sequence finish_s;
		!busy && dl == $past(alu_bus.res_lo) && dh == $past(alu_bus.res_hi);
	endsequence

	sequence flags_load_s;
		nf == $past(alu_bus.nf) && vf == $past(alu_bus.vf) && zf == $past(alu_bus.zf);
	endsequence

	// Single-cycle answer keeps the master's wait loop short
	ready_pulse_a: assert property (apb_setup_s |=> pready ##1 !pready)
		else $error("ready not a single pulse");
	unmapped_err_a: assert property (apb_setup_s and (idx < IDX_SRC_LO) |=>
		pslverr && prdata == 32'h0000_0000)
		else $error("unmapped address not refused");
	start_busy_a: assert property (start_wr |=> busy && cnt == '0) // RULE7
		else $error("start did not raise status bit");
	finish_sync_a: assert property (done |=> finish_s and flags_load_s) // RULE15
		else $error("results and flags not loaded at finish");
	done_event_a: assert property (done |=> irq_stat[IRQ_DONE_BIT])
		else $error("finish did not set event bit");
	// Only a finish may move the destination while the unit owns it
	dest_lock_a: assert property (busy && !done |=> $stable(dl) && $stable(dh))
		else $error("destination changed during run");

endmodule

/* core/imd_pkg.sv */
// Constants, types and decode helpers of the integer multiply/divide unit.
// Assumes an APB master with 32-bit data; one nibble register per word.
// Overview of operation
// RULE1: Overflow flag shows last division overflowed
// RULE2: Finished multiply always clears overflow flag
// RULE3: Overflow flag read-only, reset to zero
// RULE4: Zero flag set when result is zero
// RULE5: Zero flag read-only, reset to zero
// RULE6: Writing mode bit starts divide or multiply
// RULE7: Mode bit reads one while computing
// RULE8: Reset clears mode bit to idle
// RULE9: Operation lasts ten clock cycles
// RULE10: CPU avoids results and flags while busy
// RULE11: Negative flag mirrors result MSB, read-only
// RULE12: Multiply ignores high byte, loads product
// RULE13: Divide: quotient low, remainder high, overflow keeps
// RULE14: Overflow when quotient exceeds eight bits
// RULE15: Flags, results and idle update together
package imd_pkg;

	localparam int ADDR_W = 18;
	localparam int IDX_W  = 16;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_SRC_LO   = 16'hFF80;
	localparam logic [IDX_W-1:0] IDX_SRC_HI   = 16'hFF81;
	localparam logic [IDX_W-1:0] IDX_DL_LO    = 16'hFF82;
	localparam logic [IDX_W-1:0] IDX_DL_HI    = 16'hFF83;
	localparam logic [IDX_W-1:0] IDX_DH_LO    = 16'hFF84;
	localparam logic [IDX_W-1:0] IDX_DH_HI    = 16'hFF85;
	localparam logic [IDX_W-1:0] IDX_CTRL     = 16'hFF86;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 16'hFF8A;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hFF8B;

	// Control/status field positions
	localparam int MODE_BIT = 0;
	localparam int ZF_BIT   = 1;
	localparam int VF_BIT   = 2;
	localparam int NF_BIT   = 3;

	// Interrupt status layout
	localparam int IRQ_N        = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_OVF_BIT  = 1;

	localparam int         CNT_W     = 4;
	localparam logic [3:0] OP_CYCLES = 4'hA;
	localparam logic [7:0] BYTE_RST  = 8'h00;

	typedef enum logic {
		IMD_MUL = 1'b0,
		IMD_DIV = 1'b1
	} imd_mode_t;

	typedef enum logic [1:0] {
		IMD_IDLE = 2'b00,
		IMD_RUN  = 2'b01
	} imd_state_t;

	// Word index of a byte address, or all ones if misaligned
	function automatic logic [IDX_W-1:0] imd_idx(input logic [ADDR_W-1:0] a);
		if (a[1:0] != 2'h0) begin
			return '1;
		end
		return a[ADDR_W-1:2];
	endfunction

endpackage

/* core/imd_alu_if.sv */
// Operand and result bundle between the unit's control and its arithmetic.
// Assumes both ends share pclk.
interface imd_alu_if;
	import imd_pkg::*;
	imd_mode_t  mode;
	logic [7:0] src;
	logic [7:0] dh;
	logic [7:0] dl;
	logic [7:0] res_lo;
	logic [7:0] res_hi;
	logic       nf;
	logic       vf;
	logic       zf;

	modport ctl (output mode, src, dh, dl, input res_lo, res_hi, nf, vf, zf);
	modport alu (input mode, src, dh, dl, output res_lo, res_hi, nf, vf, zf);
endinterface

/* core/imd_alu.sv */
// Unsigned 8x8 multiply and 16/8 divide on captured operands.
// Assumes operands stay stable for the whole run; results are registered.
module imd_alu
	import imd_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	imd_alu_if.alu    bus
);

	logic [15:0] dividend;
	logic [15:0] quot;
	logic [15:0] prod;
	logic [7:0]  rem;
	logic        ovf;
	logic [7:0]  next_lo;
	logic [7:0]  next_hi;
	logic        next_nf;
	logic        next_vf;
	logic        next_zf;

	always_comb begin
		dividend = {bus.dh, bus.dl};
		prod     = {8'h00, bus.src} * {8'h00, bus.dl};
		// Quotient too wide exactly when the high byte reaches the divisor
		ovf      = (bus.dh >= bus.src); // RULE14
		// Zero divisor reported as overflow, no quotient to form
		quot     = (bus.src == 8'h00) ? 16'hFFFF : dividend / {8'h00, bus.src};
		rem      = (bus.src == 8'h00) ? 8'h00 : 8'(dividend % {8'h00, bus.src});
		if (bus.mode == IMD_MUL) begin
			next_lo = prod[7:0]; // RULE12
			next_hi = prod[15:8]; // RULE12
			next_nf = prod[15]; // RULE11
			next_vf = 1'b0; // RULE2
			next_zf = (prod == 16'h0000); // RULE4
		end else begin
			next_lo = ovf ? bus.dl : quot[7:0]; // RULE13
			next_hi = ovf ? bus.dh : rem; // RULE13
			next_nf = quot[7]; // RULE11
			next_vf = ovf; // RULE1
			next_zf = (quot[7:0] == 8'h00); // RULE14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.res_lo <= BYTE_RST;
			bus.res_hi <= BYTE_RST;
			bus.nf     <= 1'b0;
			bus.vf     <= 1'b0;
			bus.zf     <= 1'b0;
		end else begin
			bus.res_lo <= next_lo;
			bus.res_hi <= next_hi;
			bus.nf     <= next_nf;
			bus.vf     <= next_vf;
			bus.zf     <= next_zf;
		end
	end

endmodule

/* core/imd_irq.sv */
// Sticky event bits with write-one-to-clear, a mask and one level output.
// Assumes one-cycle event pulses and one-cycle write strobes.
module imd_irq #(
	parameter int N = 2
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [N-1:0] evt,
	input  wire logic         stat_wr,
	input  wire logic         mask_wr,
	input  wire logic [N-1:0] wdata,
	output logic      [N-1:0] stat,
	output logic      [N-1:0] mask,
	output logic              irq
);

	logic [N-1:0] next_stat;
	logic [N-1:0] next_mask;
	logic         next_irq;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			// A new event beats a clear in the same cycle
			assign next_stat[i] = evt[i] | (stat[i] & ~(stat_wr & wdata[i]));
		end
	endgenerate

	always_comb begin
		next_mask = mask_wr ? wdata : mask;
		next_irq  = |(next_stat & next_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= '0;
			mask <= '0;
			irq  <= 1'b0;
		end else begin
			stat <= next_stat;
			mask <= next_mask;
			irq  <= next_irq;
		end
	end

endmodule

/* tb/imd_cpu.sv */
// APB master standing in for the CPU core on the I/O bus.
// Assumes one imd_top slave on the same pclk; one transfer per call.
module imd_cpu
	import imd_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic      [ADDR_W-1:0] paddr,
	output logic      [31:0]       pwdata,
	output logic      [3:0]        pstrb,
	output logic      [32:0]       rd_res,
	output int                     rd_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'h0;
		rd_res = '0;
		rd_cnt = 0;
	end

	task automatic xfer(input logic w, input logic [IDX_W-1:0] i, input logic [3:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {28'h0, d};
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w) begin
			rd_res <= {pslverr, prdata};
			rd_cnt <= rd_cnt + 1;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines must not keep the old value
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule

/* tb/imd_top_tb_top.sv */
// Self-checking bench of the multiply/divide unit.
// Assumes imd_top and the imd_cpu bus master; reads checked as they land.
module imd_top_tb_top
	import imd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {
		string       name;
		logic [32:0] v;
		logic [32:0] m;
	} imd_exp_t;
	localparam logic [32:0] ALL = '1;

	imd_exp_t          q[$];
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel, penable, pwrite, pready, pslverr, irq;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic [3:0]        pstrb;
	logic [32:0]       rd_res;
	int                rd_cnt, seen = 0, n_fail = 0, cmp_count = 0, cyc = 0;
	logic [31:0]       rs = 32'h000182F9;

	always #5 pclk = ~pclk;

	imd_top i_imd_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .irq);
	imd_cpu i_imd_cpu (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .rd_res, .rd_cnt);

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check_rd(input imd_exp_t e, input logic [32:0] s);
		cmp_count++;
		if ((s & e.m) !== (e.v & e.m)) begin
			n_fail++;
			$display("BAD %s exp %h got %h", e.name, e.v & e.m, s & e.m);
		end
	endtask

	task automatic check_bit(input string n, input logic e, input logic s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s exp %b got %b", n, e, s);
		end
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (rd_cnt != seen) begin
			seen = rd_cnt;
			check_rd(q.pop_front(), rd_res);
		end
		if (cyc == 30000) begin
			n_fail++;
			$display("timeout");
			print_verdict();
		end
	end

	task automatic wr(input logic [IDX_W-1:0] i, input logic [3:0] d);
		i_imd_cpu.xfer(1'b1, i, d);
	endtask

	task automatic rd(input string n, input logic [IDX_W-1:0] i, input logic [32:0] v,
		input logic [32:0] m);
		q.push_back('{n, v, m});
		i_imd_cpu.xfer(1'b0, i, 4'h0);
	endtask

	task automatic wr8(input logic [IDX_W-1:0] i, input logic [7:0] d);
		wr(i, d[3:0]);
		wr(i + 16'h0001, d[7:4]);
	endtask

	task automatic rd8(input string n, input logic [IDX_W-1:0] i, input logic [7:0] d);
		rd(n, i, {29'h0, d[3:0]}, ALL);
		rd(n, i + 16'h0001, {29'h0, d[7:4]}, ALL);
	endtask

	task automatic op(input logic dv, input logic [7:0] s, input logic [7:0] h,
		input logic [7:0] l, input int c);
		logic [15:0] qt;
		logic [15:0] rm;
		logic [15:0] p;
		logic [31:0] r;
		logic        ov;
		logic [3:0]  f;
		qt = (s == 8'h00) ? 16'hFFFF : {h, l} / s;
		rm = (s == 8'h00) ? 16'h0000 : {h, l} % s;
		p = s * l;
		ov = dv && (h >= s);
		f = dv ? {qt[7], ov, qt[7:0] == 8'h00, 1'b0} : {p[15], 1'b0, p == 16'h0000, 1'b0};
		r = rnd();
		wr8(IDX_SRC_LO, s);
		wr8(IDX_DL_LO, l);
		wr8(IDX_DH_LO, h);
		// Junk in the flag bits must not stick
		wr(IDX_CTRL, {r[3:1], dv});
		repeat (c) @(posedge pclk);
		if (c < 9)
			rd("busy", IDX_CTRL, 33'h1, 33'h1);
		rd("ctrl", IDX_CTRL, {29'h0, f}, ALL);
		rd8("dl", IDX_DL_LO, !dv ? p[7:0] : ov ? l : qt[7:0]);
		rd8("dh", IDX_DH_LO, !dv ? p[15:8] : ov ? h : rm[7:0]);
	endtask

	initial begin
		logic [7:0] a, b, d;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd("ctrl_rst", IDX_CTRL, 33'h0, ALL);
		rd("stat_rst", IDX_IRQ_STAT, 33'h0, ALL);
		rd("unmapped", 16'h0010, {1'b1, 32'h0}, ALL);
		$display("reset test done");
		op(1'b1, 8'h13, 8'h24, 8'h68, 9);
		rd("stat", IDX_IRQ_STAT, 33'h3, ALL);
		check_bit("irq_masked", 1'b0, irq);
		wr(IDX_IRQ_MASK, 4'h3);
		repeat (2) @(posedge pclk);
		#1 check_bit("irq_on", 1'b1, irq);
		wr(IDX_IRQ_STAT, 4'h1);
		rd("stat_w1c", IDX_IRQ_STAT, 33'h2, ALL);
		check_bit("irq_ovf", 1'b1, irq);
		wr(IDX_IRQ_STAT, 4'h2);
		repeat (2) @(posedge pclk);
		#1 check_bit("irq_off", 1'b0, irq);
		rd("mask", IDX_IRQ_MASK, 33'h3, ALL);
		$display("interrupt test done");
		op(1'b0, 8'hFF, 8'h55, 8'hFF, 8);
		op(1'b1, 8'h64, 8'h1A, 8'h16, 9);
		op(1'b1, 8'h64, 8'h33, 8'h2C, 8);
		op(1'b1, 8'h58, 8'h00, 8'h00, 9);
		op(1'b1, 8'h00, 8'h12, 8'h34, 8);
		op(1'b0, 8'h00, 8'h77, 8'h9A, 9);
		$display("example test done");
		for (int k = 0; k < 12; k++) begin
			a = 8'(rnd());
			b = 8'(rnd());
			d = 8'(rnd());
			op(k[0], a, k[1] ? (b & 8'h0F) : b, d, 8 + k % 2);
		end
		$display("random test done");
		repeat (4) @(posedge pclk);
		print_verdict();
	end
endmodule
